// ===== bench/vme_far_master.sv
/*
  Far-end VME master: issues one slave request a cycle on command.
  Assumes the bench raises send_i for one cycle with the request beside it.
*/
`timescale 1ns/1ns
module vme_far_master (
  input  wire logic                   clk_i,
  input  wire logic                   send_i,
  input  wire vme_map_pkg::vme_sreq_t req_i,
  output logic                        valid_o,
  output vme_map_pkg::vme_sreq_t      req_o
);
  import vme_map_pkg::*;
  initial valid_o = 1'h0;
  initial req_o = '0;
  // After a request the lines show the inverse of its value until the next one.
  always @(posedge clk_i)
  begin
    valid_o <= send_i;
    if (send_i)
      req_o <= req_i;
    else if (valid_o)
      req_o <= ~req_o;
  end
endmodule

// ===== bench/vme_window_bridge_bench.sv
/*
  Self-checking bench of the VME window bridge.
  Assumes the bound checker and the far-end master model.
*/
`timescale 1ns/1ns
module vme_window_bridge_bench;
  import vme_map_pkg::*;
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic hv = 1'h0, cen = 1'h1, send = 1'h0;
  logic mv, mref, sv, hit, mbox, sref, pready, pslverr;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, dvma;
  host_req_t hreq = '0;
  vme_sreq_t sreq_in = '0, sreq;
  vme_mcyc_t mcyc;
  int failures = 0, comparisons = 0;
  always #5 clk = ~clk;
  vme_far_master i_far (.clk_i(clk), .send_i(send), .req_i(sreq_in), .valid_o(sv),
    .req_o(sreq));
  vme_window_bridge i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .HOST_VALID_I(hv), .HOST_REQ_I(hreq),
    .MCYC_VALID_O(mv), .MCYC_O(mcyc), .MCYC_REFUSED_O(mref), .SREQ_VALID_I(sv),
    .SREQ_I(sreq), .CHIP_SLAVE_EN_I(cen), .SLV_HIT_O(hit), .SLV_DVMA_ADDR_O(dvma),
    .SLV_MAILBOX_O(mbox), .SLV_REFUSED_O(sref));
  // ******************************************************************
  // Bus and comparison tasks
  // ******************************************************************
  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'h1; pwr <= w; paddr <= {24'h0, a}; pwdata <= d;
    @(posedge clk);
    pen <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 50);
    r = prdata;
    er = pslverr;
    psel <= 1'h0; pen <= 1'h0;
    if (n >= 50)
    begin
      chk("pready", 32'h1, 32'h0);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    apb(1'h1, a, d, r, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic ee);
    logic [31:0] r;
    logic er;
    apb(1'h0, a, 32'h0, r, er);
    chk("prdata", e, r);
    chk("pslverr", 32'(ee), 32'(er));
  endtask
  task automatic host(input logic [31:0] a, input xfer_size_t s, input logic [1:0] k,
                      input logic [31:0] ea, input logic [5:0] am, input logic [3:0] ln);
    @(posedge clk);
    hv <= 1'h1; hreq <= '{a, s, a[2]};
    @(posedge clk);
    hv <= 1'h0;
    #1 chk("refused_valid", 32'(k), 32'({mref, mv}));
    if (k == 2'h1)
    begin
      chk("vme_addr", ea, mcyc.addr);
      chk("vme_am", 32'(am), 32'(mcyc.am));
      chk("vme_lanes", 32'(ln), 32'(mcyc.lanes));
      chk("vme_write", 32'(a[2]), 32'(mcyc.write));
    end
  endtask
  task automatic slv(input logic [31:0] a, input logic [5:0] am, input xfer_size_t s,
                     input logic [2:0] k, input logic [31:0] ed);
    @(posedge clk);
    send <= 1'h1; sreq_in <= '{a, am, s};
    @(posedge clk);
    send <= 1'h0;
    @(posedge clk);
    #1 chk("refused_mbox_hit", 32'(k), 32'({sref, mbox, hit}));
    if (k == 3'h1)
      chk("dvma", ed, dvma);
  endtask
  // ******************************************************************
  // Scenarios
  // ******************************************************************
  task automatic t_regs;
    rd(8'h0C, 32'h0, 1'h0);
    rd(8'h10, 32'h0, 1'h0);
    rd(8'h1C, 32'h0, 1'h0);
    rd(8'h04, 32'h0, 1'h1);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h77, 1'h0);
    wr(8'h10, 32'hFF);
    rd(8'h10, 32'h0F, 1'h0);
  endtask
  task automatic t_master;
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h5);
    host(32'h6123_4568, XFER_WORD, 2'h1, 32'h5123_4568, 6'h09, 4'hF);
    host(32'h7123_4568, XFER_WORD, 2'h0, 32'h0, 6'h0, 4'h0);
    host(32'h6123_4566, XFER_WORD, 2'h2, 32'h0, 6'h0, 4'h0);
    host(32'h6000_0001, XFER_HALF, 2'h2, 32'h0, 6'h0, 4'h0);
    host(32'h6FFF_0008, XFER_WORD, 2'h1, 32'h5FFF_0008, 6'h09, 4'hF);
    wr(8'h10, 32'hF);
    host(32'h6FFF_0008, XFER_WORD, 2'h1, 32'h0000_0008, 6'h29, 4'hF);
    wr(8'h0C, 32'h20);
    host(32'h6123_4568, XFER_WORD, 2'h1, 32'hF123_4568, 6'h0D, 4'hF);
    host(32'h6FFF_1234, XFER_HALF, 2'h1, 32'h0000_1234, 6'h2D, 4'h3);
    host(32'h6F12_3457, XFER_BYTE, 2'h1, 32'h0012_3457, 6'h3D, 4'h1);
    host(32'h6F12_3456, XFER_BYTE, 2'h1, 32'h0012_3456, 6'h3D, 4'h2);
    rd(8'h28, 32'h02, 1'h0);
  endtask
  task automatic t_slave;
    wr(8'h20, 32'h8010_0000);
    wr(8'h0C, 32'h06);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h0, 32'h0);
    wr(8'h1C, 32'h08);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h1, 32'hFC10_0040);
    cen <= 1'h0;
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h0, 32'h0);
    cen <= 1'h1;
    wr(8'h0C, 32'h00);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h1, 32'hFFF0_0040);
    slv(32'h8020_0040, 6'h09, XFER_WORD, 3'h4, 32'h0);
    slv(32'h8010_0042, 6'h09, XFER_WORD, 3'h4, 32'h0);
    slv(32'h8010_0040, 6'h0B, XFER_WORD, 3'h0, 32'h0);
    slv(32'h0000_1000, 6'h2D, XFER_WORD, 3'h2, 32'h0);
    wr(8'h0C, 32'h07);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h4, 32'h0);
    wr(8'h0C, 32'h10);
    slv(32'h0010_0040, 6'h39, XFER_WORD, 3'h1, 32'hFFF0_0040);
    rd(8'h28, 32'h0A, 1'h0);
  endtask
  task automatic t_default;
    wr(8'h20, 32'h8000_0000);
    wr(8'h24, 32'h1);
    wr(8'h0C, 32'h40);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h1, 32'hFFF0_0040);
    slv(32'h8020_0040, 6'h09, XFER_WORD, 3'h4, 32'h0);
    wr(8'h0C, 32'h00);
    slv(32'h8010_0040, 6'h09, XFER_WORD, 3'h4, 32'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (4) @(posedge clk);
    t_regs();
    t_master();
    t_slave();
    t_default();
    give_verdict();
  end
endmodule

// ===== bench/vme_window_bridge_chk.sv
/*
  Port checker for the VME window bridge.
  Assumes one clock domain and the active-low reset of the top module.
*/
`timescale 1ns/1ns
module vme_window_bridge_chk #(
  parameter int SLAVE_SIZE_CODES = 7
) (
  input wire logic                   CLOCK_I,
  input wire logic                   RST_N_I,
  input wire logic                   HOST_VALID_I,
  input wire vme_map_pkg::host_req_t HOST_REQ_I,
  input wire logic                   MCYC_VALID_O,
  input wire vme_map_pkg::vme_mcyc_t MCYC_O,
  input wire logic                   MCYC_REFUSED_O,
  input wire logic                   SREQ_VALID_I,
  input wire vme_map_pkg::vme_sreq_t SREQ_I,
  input wire logic                   CHIP_SLAVE_EN_I,
  input wire logic                   SLV_HIT_O,
  input wire logic [31:0]            SLV_DVMA_ADDR_O,
  input wire logic                   SLV_MAILBOX_O
);
  import vme_map_pkg::*;
  wire        in_win   = HOST_VALID_I && (HOST_REQ_I.addr[31:28] == 4'h6);
  wire [27:0] host_low = HOST_REQ_I.addr[27:0];
  wire [5:0]  sreq_am  = SREQ_I.am;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  property p_out_win;
    HOST_VALID_I && !in_win |=> !MCYC_VALID_O && !MCYC_REFUSED_O;
  endproperty
  a_out_win: assert property (p_out_win) else $error("pulse outside window");
  property p_am_set;
    MCYC_VALID_O |-> MCYC_O.am inside {6'h29, 6'h2D, 6'h39, 6'h3D, 6'h09, 6'h0D};
  endproperty
  a_am_set: assert property (p_am_set) else $error("illegal modifier");
  property p_a32_pass;
    MCYC_VALID_O && MCYC_O.am[5:3] == 3'h1 |-> MCYC_O.addr[27:0] == $past(host_low);
  endproperty
  a_a32_pass: assert property (p_a32_pass) else $error("A32 low bits changed");
  property p_half_lanes;
    in_win && HOST_REQ_I.size == XFER_HALF && !HOST_REQ_I.addr[0]
      |=> MCYC_VALID_O && MCYC_O.lanes == 4'h3;
  endproperty
  a_half_lanes: assert property (p_half_lanes) else $error("half lanes wrong");
  property p_unaligned;
    in_win && HOST_REQ_I.size == XFER_WORD && HOST_REQ_I.addr[1:0] != 2'h0
      |=> MCYC_REFUSED_O && !MCYC_VALID_O;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned not refused");
  property p_chip_off;
    SREQ_VALID_I && !CHIP_SLAVE_EN_I |=> !SLV_HIT_O && !SLV_MAILBOX_O;
  endproperty
  a_chip_off: assert property (p_chip_off) else $error("slave answered while off");
  property p_dvma_top;
    SLV_HIT_O |-> SLV_DVMA_ADDR_O[31:26] == 6'h3F;
  endproperty
  a_dvma_top: assert property (p_dvma_top) else $error("DVMA not at top");
  property p_mailbox;
    SLV_MAILBOX_O |-> $past(sreq_am) inside {6'h29, 6'h2D} && !SLV_HIT_O;
  endproperty
  a_mailbox: assert property (p_mailbox) else $error("mailbox without A16");
endmodule

bind vme_window_bridge vme_window_bridge_chk #(.SLAVE_SIZE_CODES(SLAVE_SIZE_CODES)) i_chk (
  .CLOCK_I, .RST_N_I, .HOST_VALID_I, .HOST_REQ_I, .MCYC_VALID_O, .MCYC_O,
  .MCYC_REFUSED_O, .SREQ_VALID_I, .SREQ_I, .CHIP_SLAVE_EN_I, .SLV_HIT_O,
  .SLV_DVMA_ADDR_O, .SLV_MAILBOX_O
);

// ===== logic/slave_window_match.sv
/*
  Slave window comparator: decides whether a VME slave address falls in the
  on-board DRAM window and places it at the top of the DVMA space.
  Assumes the caller has already checked the address modifier and the gate.
*/
`timescale 1ns/1ns
module slave_window_match #(
  parameter int SIZE_CODES = 7
) (
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] base_i,
  input  wire logic [3:0]  page_i,
  input  wire logic [2:0]  size_i,
  input  wire logic        mode_default_i,
  input  wire logic        a24_i,
  output logic             hit_o,
  output logic [31:0]      dvma_o
);
  import vme_map_pkg::*;

  logic [31:0] mask;
  logic [31:0] amask;
  logic [31:0] diff;

  always_comb
  begin
    // Default mode is always a 1 Mbyte page, enhanced mode scales it.
    if (mode_default_i)
      mask = 32'h000F_FFFF;
    else
      mask = (32'h0010_0000 << size_i) - 32'h0000_0001;
    amask = a24_i ? A24_ADDR_MASK : 32'hFFFF_FFFF;
    diff  = (addr_i ^ base_i) & amask;
    if (mode_default_i)
      hit_o = (addr_i[23:20] == page_i) && (diff[31:24] == 8'h00);
    else
      hit_o = (32'(size_i) < 32'(SIZE_CODES)) && ((diff & ~mask) == 32'h0000_0000);
    dvma_o = ~mask | (addr_i & mask);
  end

endmodule

// ===== logic/vme_map_pkg.sv
/*
  Shared constants and carrier types of the host to VMEbus window bridge.
  Assumes a 32-bit APB register bus and synchronous pins on one clock.
*/
package vme_map_pkg;

  // ******************************************************************
  // Register offsets (printed offsets are indices, byte address is x4)
  // ******************************************************************
  localparam logic [31:0] REG_BLOCK_BASE      = 32'h7138_0000;
  localparam logic [31:0] OFS_VME_CONTROL     = 32'h7138_0003;
  localparam logic [31:0] OFS_VME_HIGH_MAP    = 32'h7138_0004;
  localparam logic [31:0] OFS_GENERAL_TWO     = 32'h7138_0007;
  localparam logic [31:0] OFS_SLAVE_BASE      = 32'h7138_0008;
  localparam logic [31:0] OFS_SLAVE_PAGE      = 32'h7138_0009;
  localparam logic [31:0] OFS_BRIDGE_STATUS   = 32'h7138_000A;
  localparam int          APB_ADDR_W          = 8;

  // ******************************************************************
  // Field positions and reset values
  // ******************************************************************
  localparam int          CTL_MODE_BIT        = 6;
  localparam int          CTL_PRIV_BIT        = 5;
  localparam int          CTL_WIDTH_BIT       = 4;
  localparam int          CTL_SIZE_LSB        = 0;
  localparam int          GP2_GATE_BIT        = 3;
  localparam logic [7:0]  CTL_RESET           = 8'h00;
  localparam logic [3:0]  HIGH_MAP_RESET      = 4'h0;
  localparam logic [31:0] SLAVE_BASE_RESET    = 32'h0000_0000;
  localparam logic [3:0]  SLAVE_PAGE_RESET    = 4'h0;

  // ******************************************************************
  // Host window and VME address spaces
  // ******************************************************************
  localparam logic [3:0]  HOST_WIN_NIBBLE     = 4'h6;
  localparam logic [15:0] A16_SPACE_TOP       = 16'hFFFF;
  localparam logic [7:0]  A24_SPACE_TOP       = 8'hFF;
  localparam logic [5:0]  AM_A16_NONPRIV      = 6'h29;
  localparam logic [5:0]  AM_A24_NONPRIV      = 6'h39;
  localparam logic [5:0]  AM_A32_NONPRIV      = 6'h09;
  localparam logic [5:0]  AM_PRIV_MASK        = 6'h04;
  localparam logic [31:0] A16_ADDR_MASK       = 32'h0000_FFFF;
  localparam logic [31:0] A24_ADDR_MASK       = 32'h00FF_FFFF;
  localparam logic [2:0]  WIN_SIZE_NONE       = 3'h7;

  typedef enum logic [1:0] {
    XFER_BYTE = 2'h0,
    XFER_HALF = 2'h1,
    XFER_WORD = 2'h2
  } xfer_size_t;

  typedef enum logic [2:0] {
    SPACE_A32 = 3'h1,
    SPACE_A24 = 3'h2,
    SPACE_A16 = 3'h4
  } vme_space_t;

  typedef struct packed {
    logic [31:0] addr;
    xfer_size_t  size;
    logic        write;
  } host_req_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  am;
    logic [3:0]  lanes;
    logic        write;
  } vme_mcyc_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [5:0]  am;
    xfer_size_t  size;
  } vme_sreq_t;

endpackage

// ===== logic/vme_window_bridge.sv
/*
  Host to VMEbus address window bridge: APB control registers, master
  address translation with address modifier and byte lanes, and the slave
  DVMA window decode. Assumes all pins are synchronous to CLOCK_I and that
  the VME cycle engine itself lives outside this block.
*/
// Behaviour
// - Host range 6000_0000..6FFF_FFFF becomes VME cycles
// - Map field bits 3..0 drive A31..A28, reset 0
// - Full VME address picks A32, A24 or A16
// - Only AM 2D/29, 3D/39, 0D/09 driven
// - Control bit 5 drives address modifier bit 2
// - Privilege bit resets to non-privileged
// - Byte, half and word use their documented lanes
// - No block mode, unaligned master requests refused
// - Default mode: one 1 Mbyte page in 16 Mbyte
// - Enhanced mode: variable base, seven sizes up to 64M
// - Slave window lands at top of DVMA space
// - Control bit 6 selects default or enhanced mode
// - Slave mode bit resets to enhanced mode
// - Slave answers only while gate bit 3 set
// - Gate resets 0 and must be set together with chip enable
// - Slave takes A32 and A24, A16 only mailbox
// - Slave refuses unaligned transfers, ignores block transfers
// - Control bit 4 selects slave A32 or A24
// - Control bits 2..0 set enhanced window size
`timescale 1ns/1ns
module vme_window_bridge #(
  parameter int SLAVE_SIZE_CODES = 7
) (
  // Clock and reset.
  input  wire logic                    CLOCK_I,
  input  wire logic                    RST_N_I,
  // APB register port.
  input  wire logic                    PSEL_I,
  input  wire logic                    PENABLE_I,
  input  wire logic                    PWRITE_I,
  input  wire logic [31:0]             PADDR_I,
  input  wire logic [31:0]             PWDATA_I,
  output logic [31:0]                  PRDATA_O,
  output logic                         PREADY_O,
  output logic                         PSLVERR_O,
  // Host master request and translated VME cycle.
  input  wire logic                    HOST_VALID_I,
  input  wire vme_map_pkg::host_req_t  HOST_REQ_I,
  output logic                         MCYC_VALID_O,
  output vme_map_pkg::vme_mcyc_t       MCYC_O,
  output logic                         MCYC_REFUSED_O,
  // VME slave request and DVMA answer.
  input  wire logic                    SREQ_VALID_I,
  input  wire vme_map_pkg::vme_sreq_t  SREQ_I,
  input  wire logic                    CHIP_SLAVE_EN_I,
  output logic                         SLV_HIT_O,
  output logic [31:0]                  SLV_DVMA_ADDR_O,
  output logic                         SLV_MAILBOX_O,
  output logic                         SLV_REFUSED_O
);
  import vme_map_pkg::*;

  // ******************************************************************
  // Parameter check
  // ******************************************************************
  generate
    if (SLAVE_SIZE_CODES < 1 || SLAVE_SIZE_CODES > 7)
    begin : g_bad_size
      $error("SLAVE_SIZE_CODES must lie between 1 and 7.");
    end
  endgenerate

  // ******************************************************************
  // Reset release
  // ******************************************************************
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // ******************************************************************
  // Register file
  // ******************************************************************
  localparam logic [APB_ADDR_W-1:0] ADR_CONTROL =
    APB_ADDR_W'((OFS_VME_CONTROL - REG_BLOCK_BASE) << 2);
  localparam logic [APB_ADDR_W-1:0] ADR_HIGH_MAP =
    APB_ADDR_W'((OFS_VME_HIGH_MAP - REG_BLOCK_BASE) << 2);
  localparam logic [APB_ADDR_W-1:0] ADR_GENERAL_TWO =
    APB_ADDR_W'((OFS_GENERAL_TWO - REG_BLOCK_BASE) << 2);
  localparam logic [APB_ADDR_W-1:0] ADR_SLAVE_BASE =
    APB_ADDR_W'((OFS_SLAVE_BASE - REG_BLOCK_BASE) << 2);
  localparam logic [APB_ADDR_W-1:0] ADR_SLAVE_PAGE =
    APB_ADDR_W'((OFS_SLAVE_PAGE - REG_BLOCK_BASE) << 2);
  localparam logic [APB_ADDR_W-1:0] ADR_STATUS =
    APB_ADDR_W'((OFS_BRIDGE_STATUS - REG_BLOCK_BASE) << 2);

  logic        slave_window_mode;
  logic        priv_level_select;
  logic        slave_addr_width_sel;
  logic [2:0]  slave_window_size;
  logic [3:0]  external_high_addr_reg;
  logic        slave_access_gate;
  logic [31:0] slave_base;
  logic [3:0]  slave_page;
  vme_space_t  last_space;
  logic        last_slave_hit;
  logic        last_master_refused;

  logic                  setup_phase;
  logic                  wr_access;
  logic [APB_ADDR_W-1:0] reg_addr;
  logic                  addr_mapped;
  logic                  addr_in_block;
  logic [31:0]           next_rdata;

  assign setup_phase   = PSEL_I && !PENABLE_I;
  assign wr_access     = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign reg_addr      = PADDR_I[APB_ADDR_W-1:0];
  assign addr_in_block = (PADDR_I[31:APB_ADDR_W] == '0);

  always_comb
  begin
    next_rdata  = 32'h0000_0000;
    addr_mapped = addr_in_block;
    case (reg_addr)
      ADR_CONTROL:
        begin
          next_rdata[CTL_MODE_BIT]  = slave_window_mode;
          next_rdata[CTL_PRIV_BIT]  = priv_level_select;
          next_rdata[CTL_WIDTH_BIT] = slave_addr_width_sel;
          next_rdata[CTL_SIZE_LSB +: 3] = slave_window_size;
        end
      ADR_HIGH_MAP:
        next_rdata[3:0] = external_high_addr_reg;
      ADR_GENERAL_TWO:
        next_rdata[GP2_GATE_BIT] = slave_access_gate;
      ADR_SLAVE_BASE:
        next_rdata = slave_base;
      ADR_SLAVE_PAGE:
        next_rdata[3:0] = slave_page;
      ADR_STATUS:
        next_rdata[4:0] = {last_master_refused, last_slave_hit, last_space};
      default:
        addr_mapped = 1'b0;
    endcase
    if (!addr_in_block)
      next_rdata = 32'h0000_0000;
  end

  // Zero wait states: data and error are prepared in the setup cycle.
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O <= 1'b1;
      if (setup_phase)
      begin
        PRDATA_O  <= PWRITE_I ? 32'h0000_0000 : next_rdata;
        PSLVERR_O <= !addr_mapped;
      end
    end
  end

  // Control register: reserved bits 7 and 3 are not stored.
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slave_window_mode    <= CTL_RESET[CTL_MODE_BIT];
      priv_level_select    <= CTL_RESET[CTL_PRIV_BIT];
      slave_addr_width_sel <= CTL_RESET[CTL_WIDTH_BIT];
      slave_window_size    <= CTL_RESET[CTL_SIZE_LSB +: 3];
    end
    else if (wr_access && addr_mapped && reg_addr == ADR_CONTROL)
    begin
      slave_window_mode    <= PWDATA_I[CTL_MODE_BIT];
      priv_level_select    <= PWDATA_I[CTL_PRIV_BIT];
      slave_addr_width_sel <= PWDATA_I[CTL_WIDTH_BIT];
      slave_window_size    <= PWDATA_I[CTL_SIZE_LSB +: 3];
    end
  end

  // Upper address, slave gate and slave window placement.
  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      external_high_addr_reg <= HIGH_MAP_RESET;
      slave_access_gate      <= 1'b0;
      slave_base             <= SLAVE_BASE_RESET;
      slave_page             <= SLAVE_PAGE_RESET;
    end
    else if (wr_access && addr_mapped)
    begin
      if (reg_addr == ADR_HIGH_MAP)
        external_high_addr_reg <= PWDATA_I[3:0];
      if (reg_addr == ADR_GENERAL_TWO)
        slave_access_gate <= PWDATA_I[GP2_GATE_BIT];
      if (reg_addr == ADR_SLAVE_BASE)
        slave_base <= PWDATA_I;
      if (reg_addr == ADR_SLAVE_PAGE)
        slave_page <= PWDATA_I[3:0];
    end
  end

  // ******************************************************************
  // Master translation
  // ******************************************************************
  logic        host_hit;
  logic [31:0] full_addr;
  vme_space_t  space;
  logic        aligned;
  logic [3:0]  lanes;
  logic [5:0]  am;
  logic [31:0] vme_addr;

  // Software must already have set A31..A28 for the short and standard ranges.
  assign host_hit  = HOST_REQ_I.addr[31:28] == HOST_WIN_NIBBLE;
  assign full_addr = {external_high_addr_reg, HOST_REQ_I.addr[27:0]};

  always_comb
  begin
    if (full_addr[31:16] == A16_SPACE_TOP)
    begin
      space    = SPACE_A16;
      vme_addr = full_addr & A16_ADDR_MASK;
      am       = AM_A16_NONPRIV;
    end
    else if (full_addr[31:24] == A24_SPACE_TOP)
    begin
      space    = SPACE_A24;
      vme_addr = full_addr & A24_ADDR_MASK;
      am       = AM_A24_NONPRIV;
    end
    else
    begin
      space    = SPACE_A32;
      vme_addr = full_addr;
      am       = AM_A32_NONPRIV;
    end
    if (priv_level_select)
      am = am | AM_PRIV_MASK;
  end

  // VME even byte sits on D15..D08, odd byte on D07..D00.
  always_comb
  begin
    case (HOST_REQ_I.size)
      XFER_BYTE:
        begin
          aligned = 1'b1;
          lanes   = HOST_REQ_I.addr[0] ? 4'h1 : 4'h2;
        end
      XFER_HALF:
        begin
          aligned = !HOST_REQ_I.addr[0];
          lanes   = 4'h3;
        end
      XFER_WORD:
        begin
          aligned = HOST_REQ_I.addr[1:0] == 2'h0;
          lanes   = 4'hF;
        end
      default:
        begin
          aligned = 1'b0;
          lanes   = 4'h0;
        end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      MCYC_VALID_O        <= 1'b0;
      MCYC_REFUSED_O      <= 1'b0;
      MCYC_O              <= '0;
      last_space          <= SPACE_A32;
      last_master_refused <= 1'b0;
    end
    else
    begin
      MCYC_VALID_O   <= HOST_VALID_I && host_hit && aligned;
      MCYC_REFUSED_O <= HOST_VALID_I && host_hit && !aligned;
      if (HOST_VALID_I && host_hit)
      begin
        last_master_refused <= !aligned;
        if (aligned)
        begin
          MCYC_O.addr  <= vme_addr;
          MCYC_O.am    <= am;
          MCYC_O.lanes <= lanes;
          MCYC_O.write <= HOST_REQ_I.write;
          last_space   <= space;
        end
      end
    end
  end

  // ******************************************************************
  // Slave decode
  // ******************************************************************
  logic        win_hit;
  logic [31:0] win_dvma;
  logic        am_a32;
  logic        am_a24;
  logic        am_a16;
  logic        s_aligned;
  logic        s_enabled;
  logic        s_take;

  slave_window_match #(
    .SIZE_CODES (SLAVE_SIZE_CODES)
  ) u_match (
    .addr_i         (SREQ_I.addr),
    .base_i         (slave_base),
    .page_i         (slave_page),
    .size_i         (slave_window_size),
    .mode_default_i (slave_window_mode),
    .a24_i          (slave_addr_width_sel),
    .hit_o          (win_hit),
    .dvma_o         (win_dvma)
  );

  // Block transfer modifiers match none of these and are ignored, not refused.
  assign am_a32 = (SREQ_I.am | AM_PRIV_MASK) == (AM_A32_NONPRIV | AM_PRIV_MASK);
  assign am_a24 = (SREQ_I.am | AM_PRIV_MASK) == (AM_A24_NONPRIV | AM_PRIV_MASK);
  assign am_a16 = (SREQ_I.am | AM_PRIV_MASK) == (AM_A16_NONPRIV | AM_PRIV_MASK);
  assign s_aligned = (SREQ_I.size == XFER_BYTE)
                  || (SREQ_I.size == XFER_HALF && !SREQ_I.addr[0])
                  || (SREQ_I.size == XFER_WORD && SREQ_I.addr[1:0] == 2'h0);
  assign s_enabled = slave_access_gate && CHIP_SLAVE_EN_I;
  assign s_take    = SREQ_VALID_I && s_enabled && s_aligned && win_hit
                  && (slave_addr_width_sel ? am_a24 : am_a32);

  always_ff @(posedge CLOCK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      SLV_HIT_O       <= 1'b0;
      SLV_MAILBOX_O   <= 1'b0;
      SLV_REFUSED_O   <= 1'b0;
      SLV_DVMA_ADDR_O <= 32'h0000_0000;
      last_slave_hit  <= 1'b0;
    end
    else
    begin
      SLV_HIT_O     <= s_take;
      SLV_MAILBOX_O <= SREQ_VALID_I && s_enabled && am_a16;
      SLV_REFUSED_O <= SREQ_VALID_I && s_enabled && !am_a16
                    && (am_a32 || am_a24) && (!s_aligned || !win_hit);
      if (s_take)
        SLV_DVMA_ADDR_O <= win_dvma;
      if (SREQ_VALID_I && s_enabled)
        last_slave_hit <= s_take;
    end
  end

endmodule
